/* design/hcad_defs.vh */
// Constants for the heater current alarm detector: register map, fields,
// reset values and timing. Assumes inclusion by every hcad design file.
`ifndef HCAD_DEFS_VH
`define HCAD_DEFS_VH

// Clock and least evaluated interval
`define HCAD_CLK_KHZ        125000
`define HCAD_MIN_IVL_MS     100
`define HCAD_MIN_IVL_CYC    (`HCAD_MIN_IVL_MS * `HCAD_CLK_KHZ)
`define HCAD_CNT_W          24

// Current values in 0.1 A steps
`define HCAD_CUR_W          11
`define HCAD_CUR_ZERO       11'h000
`define HCAD_CUR_FULL       11'h3E8
`define HCAD_HYS_DEF        11'h001

// Register byte offsets; per channel pairs differ in address bit 2
`define HCAD_AW             8
`define HCAD_OFS_CTRL       8'h00
`define HCAD_OFS_CFG        8'h08
`define HCAD_OFS_HB_THR     8'h10
`define HCAD_OFS_HB_HYS     8'h18
`define HCAD_OFS_HS_THR     8'h20
`define HCAD_OFS_HS_HYS     8'h28
`define HCAD_OFS_HCUR_MON   8'h30
`define HCAD_OFS_LEAK_MON   8'h38
`define HCAD_OFS_STATUS     8'h40
`define HCAD_PAIR_MASK      8'hF8
`define HCAD_CH_BIT         2

// CTRL fields
`define HCAD_CTRL_RUN       0
`define HCAD_CTRL_SWRST     1
`define HCAD_CTRL_ERRRST    2
// CFG fields
`define HCAD_CFG_HB_LATCH   0
`define HCAD_CFG_HS_LATCH   1
`define HCAD_CFG_TYPE_LSB   4
`define HCAD_CFG_TYPE_MSB   7
`define HCAD_TYPE_NONE      4'h0
// STATUS fields
`define HCAD_ST_HB_LSB      0
`define HCAD_ST_HS_LSB      2
`define HCAD_ST_RUN         8

`endif

/* design/hcad_ivl_timer.v */
// Interval timer: tells whether the present heating ON or OFF interval
// has outlasted the least evaluated length. Assumes one clock, sync reset.
`timescale 1ns/1ps
`include "hcad_defs.vh"

module hcad_ivl_timer (
	input  wire                   i_core_clk,
	input  wire                   i_rst_n,
	input  wire                   i_level,
	input  wire [`HCAD_CNT_W-1:0] i_min_cyc,
	output wire                   o_on_ok,
	output wire                   o_off_ok
);

	reg                   lvl_q;
	reg [`HCAD_CNT_W-1:0] cnt_q;
	reg                   ok_q;

	////////////////////////////////////////////////////////////////////////
	// Restart on every edge of the heating output, qualify after min+1
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			lvl_q <= 1'b0;
			cnt_q <= {`HCAD_CNT_W{1'b0}};
			ok_q  <= 1'b0;
		end else begin
			lvl_q <= i_level;
			if (i_level != lvl_q) begin
				cnt_q <= {`HCAD_CNT_W{1'b0}};
				ok_q  <= 1'b0;
			end else if (!ok_q) begin
				cnt_q <= cnt_q + 1'b1;
				ok_q  <= (cnt_q >= i_min_cyc);      // Strictly longer
			end
		end
	end

	// Qualification always paired with the level it was earned on
	assign o_on_ok  = ok_q & lvl_q;
	assign o_off_ok = ok_q & ~lvl_q;

endmodule

/* design/hcad_alarm_chan.v */
// One sensor input's burnout and short alarm with force, hysteresis
// and latch. Assumes qualified interval flags from the interval timer.
`timescale 1ns/1ps
`include "hcad_defs.vh"

module hcad_alarm_chan (
	input  wire                   i_core_clk,
	input  wire                   i_rst_n,
	input  wire                   i_clr,
	input  wire                   i_on_ok,
	input  wire                   i_off_ok,
	input  wire [`HCAD_CUR_W-1:0] i_cur,
	input  wire [`HCAD_CUR_W-1:0] i_hb_thr,
	input  wire [`HCAD_CUR_W-1:0] i_hb_hys,
	input  wire [`HCAD_CUR_W-1:0] i_hs_thr,
	input  wire [`HCAD_CUR_W-1:0] i_hs_hys,
	input  wire                   i_hb_latch,
	input  wire                   i_hs_latch,
	output reg                    o_burnout_alarm,
	output reg                    o_short_circuit_alarm
);

	wire [`HCAD_CUR_W:0] hb_rel = {1'b0, i_hb_thr} + {1'b0, i_hb_hys};
	wire [`HCAD_CUR_W:0] cur_up = {1'b0, i_cur} + {1'b0, i_hs_hys};
	reg                  hb_d;
	reg                  hs_d;

	////////////////////////////////////////////////////////////////////////
	// Burnout: judged only inside a qualified heating ON interval
	always @* begin
		hb_d = o_burnout_alarm;                     // Hold otherwise
		if (i_hb_thr == `HCAD_CUR_ZERO)
			hb_d = 1'b0;                            // Forced off, latch freed
		else if (i_hb_thr == `HCAD_CUR_FULL)
			hb_d = 1'b1;                            // Forced on
		else if (i_on_ok && (i_cur < i_hb_thr))     // Heating output only
			hb_d = 1'b1;                            // Set beats clear
		else if (i_clr)
			hb_d = 1'b0;                            // Error reset only; soft reset acts via i_rst_n
		else if (i_hb_latch && o_burnout_alarm)
			hb_d = 1'b1;
		else if (i_on_ok && ({1'b0, i_cur} >= hb_rel))
			hb_d = 1'b0;                            // Release above band
	end

	// Short: judged only inside a qualified heating OFF interval
	always @* begin
		hs_d = o_short_circuit_alarm;               // Hold otherwise
		if (i_hs_thr == `HCAD_CUR_FULL)
			hs_d = 1'b0;                            // Forced off, latch freed
		else if (i_hs_thr == `HCAD_CUR_ZERO)
			hs_d = 1'b1;                            // Forced on
		else if (i_off_ok && (i_cur > i_hs_thr))    // Heating output only
			hs_d = 1'b1;                            // Set beats clear
		else if (i_clr)
			hs_d = 1'b0;
		else if (i_hs_latch && o_short_circuit_alarm)
			hs_d = 1'b1;
		else if (i_off_ok && (cur_up <= {1'b0, i_hs_thr}))
			hs_d = 1'b0;                            // Hysteresis below threshold
	end

	// Alarm state flops
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_burnout_alarm       <= 1'b0;
			o_short_circuit_alarm <= 1'b0;
		end else begin
			o_burnout_alarm       <= hb_d;
			o_short_circuit_alarm <= hs_d;
		end
	end

endmodule

/* design/hcad_top.v */
// Heater current alarm detector: Avalon-MM register slave, two sensor
// channels, interval timer. Assumes samples synchronous to i_core_clk.
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "hcad_defs.vh"

// Functional notes
// - During heating ON, current below burnout threshold raises burnout alarm.
// - Heating ON intervals of 100 ms or less are not judged for burnout.
// - Burnout threshold 0.0 forces alarm off, 100.0 forces on; default 0.0.
// - Burnout hysteresis 0.1 to 100.0 A, default 0.1, stops chatter.
// - Heater current monitor per sensor input is readable, 0.0 to 110.0 A.
// - Burnout alarm never alters the heating control output.
// - Latched burnout alarm clears on error reset, soft reset, power, threshold 0.0.
// - Burnout latch bit: 0 disabled, 1 enabled, default 0.
// - Heater powered after controller yields a burnout alarm.
// - Burnout detection uses only the heating output, never cooling.
// - During heating OFF, leakage above short threshold raises short alarm.
// - Heating OFF intervals of 100 ms or less are not judged for shorts.
// - Short threshold 0.0 forces alarm on, 100.0 forces off; default 100.0.
// - Short hysteresis writable only when stopped; active after soft reset or power-on.
// - Leakage current monitor per sensor input is readable, 0.0 to 110.0 A.
// - Short alarm never alters the heating control output.
// - Alarm status reads only when alarm type is not 0.
// - Short detection uses only the heating output, never cooling.
// - Latched short alarm clears on error reset, soft reset, power, threshold 100.0.
module hcad_top #(
	parameter [`HCAD_CNT_W-1:0] P_MIN_IVL_CYC = `HCAD_MIN_IVL_CYC
) (
	input  wire                   i_core_clk,
	input  wire                   i_rst_n,
	input  wire [`HCAD_AW-1:0]    i_avs_address,
	input  wire                   i_avs_read,
	input  wire                   i_avs_write,
	input  wire [31:0]            i_avs_writedata,
	output reg  [31:0]            o_avs_readdata,
	output reg                    o_avs_waitrequest,
	input  wire                   i_heat_ctrl,
	input  wire [`HCAD_CUR_W-1:0] i_current_sensor_input_0,
	input  wire [`HCAD_CUR_W-1:0] i_current_sensor_input_1,
	output reg                    o_heat_ctrl,
	output wire [1:0]             o_burnout_alarm,
	output wire [1:0]             o_short_circuit_alarm
);

	////////////////////////////////////////////////////////////////////////
	// Registers
	reg                   run_q;
	reg                   swrst_q;
	reg                   errrst_q;
	reg                   hb_latch_q;
	reg                   hs_latch_q;
	reg [3:0]             alm_type_q;
	reg [`HCAD_CUR_W-1:0] hb_thr_q  [0:1];
	reg [`HCAD_CUR_W-1:0] hb_hys_q  [0:1];
	reg [`HCAD_CUR_W-1:0] hs_thr_q  [0:1];
	reg [`HCAD_CUR_W-1:0] hs_pend_q [0:1];
	reg [`HCAD_CUR_W-1:0] hs_act_q  [0:1];
	reg [`HCAD_CUR_W-1:0] hmon_q    [0:1];
	reg [`HCAD_CUR_W-1:0] lmon_q    [0:1];
	reg [31:0]            rd_d;
	integer               i;

	wire [`HCAD_CUR_W-1:0] cur     [0:1];
	wire [`HCAD_AW-1:0]    pair    = i_avs_address & `HCAD_PAIR_MASK;
	wire                   ch      = i_avs_address[`HCAD_CH_BIT];
	wire                   wr_go   = i_avs_write & ~o_avs_waitrequest;
	wire                   rd_go   = i_avs_read & o_avs_waitrequest;
	wire                   core_rst_n = i_rst_n & ~swrst_q;
	wire                   on_ok;
	wire                   off_ok;
	wire [`HCAD_CUR_W-1:0] wdat    = i_avs_writedata[`HCAD_CUR_W-1:0];

	assign cur[0] = i_current_sensor_input_0;
	assign cur[1] = i_current_sensor_input_1;

	////////////////////////////////////////////////////////////////////////
	// Bus handshake: one wait cycle, then the transfer completes
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0000_0000;
		end else begin
			if ((i_avs_read | i_avs_write) && o_avs_waitrequest)
				o_avs_waitrequest <= 1'b0;
			else
				o_avs_waitrequest <= 1'b1;
			if (rd_go)
				o_avs_readdata <= rd_d;
		end
	end

	// Control and configuration writes
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			run_q      <= 1'b0;
			swrst_q    <= 1'b0;
			errrst_q   <= 1'b0;
			hb_latch_q <= 1'b0;
			hs_latch_q <= 1'b0;
			alm_type_q <= `HCAD_TYPE_NONE;
		end else begin
			swrst_q  <= wr_go && (pair == `HCAD_OFS_CTRL) && !ch
				&& i_avs_writedata[`HCAD_CTRL_SWRST];
			errrst_q <= wr_go && (pair == `HCAD_OFS_CTRL) && !ch
				&& i_avs_writedata[`HCAD_CTRL_ERRRST];
			if (wr_go && (pair == `HCAD_OFS_CTRL) && !ch)
				run_q <= i_avs_writedata[`HCAD_CTRL_RUN];
			if (wr_go && (pair == `HCAD_OFS_CFG) && !ch) begin
				hb_latch_q <= i_avs_writedata[`HCAD_CFG_HB_LATCH];
				hs_latch_q <= i_avs_writedata[`HCAD_CFG_HS_LATCH];
				alm_type_q <= i_avs_writedata[`HCAD_CFG_TYPE_MSB:`HCAD_CFG_TYPE_LSB];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per channel thresholds, hysteresis and current monitors
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			for (i = 0; i < 2; i = i + 1) begin
				hb_thr_q[i]  <= `HCAD_CUR_ZERO;
				hb_hys_q[i]  <= `HCAD_HYS_DEF;
				hs_thr_q[i]  <= `HCAD_CUR_FULL;
				hs_pend_q[i] <= `HCAD_HYS_DEF;
				hs_act_q[i]  <= `HCAD_HYS_DEF;      // Power-on load
				hmon_q[i]    <= `HCAD_CUR_ZERO;
				lmon_q[i]    <= `HCAD_CUR_ZERO;
			end
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				if (wr_go && (ch == i[0])) begin
					if (pair == `HCAD_OFS_HB_THR)
						hb_thr_q[i] <= wdat;
					if (pair == `HCAD_OFS_HB_HYS)
						hb_hys_q[i] <= wdat;
					if (pair == `HCAD_OFS_HS_THR)
						hs_thr_q[i] <= wdat;
					if ((pair == `HCAD_OFS_HS_HYS) && !run_q)
						hs_pend_q[i] <= wdat;       // Only while stopped
				end
				if (swrst_q)
					hs_act_q[i] <= hs_pend_q[i];    // Takes effect at soft reset
				if (i_heat_ctrl)
					hmon_q[i] <= cur[i];            // ON-time current
				else
					lmon_q[i] <= cur[i];            // OFF-time leakage
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always @* begin
		rd_d = 32'h0000_0000;
		case (pair)
		`HCAD_OFS_CTRL: begin
			if (!ch)
				rd_d[`HCAD_CTRL_RUN] = run_q;
		end
		`HCAD_OFS_CFG: begin
			if (!ch) begin
				rd_d[`HCAD_CFG_HB_LATCH] = hb_latch_q;
				rd_d[`HCAD_CFG_HS_LATCH] = hs_latch_q;
				rd_d[`HCAD_CFG_TYPE_MSB:`HCAD_CFG_TYPE_LSB] = alm_type_q;
			end
		end
		`HCAD_OFS_HB_THR:   rd_d[`HCAD_CUR_W-1:0] = hb_thr_q[ch];
		`HCAD_OFS_HB_HYS:   rd_d[`HCAD_CUR_W-1:0] = hb_hys_q[ch];
		`HCAD_OFS_HS_THR:   rd_d[`HCAD_CUR_W-1:0] = hs_thr_q[ch];
		`HCAD_OFS_HS_HYS:   rd_d[`HCAD_CUR_W-1:0] = hs_pend_q[ch];
		`HCAD_OFS_HCUR_MON: rd_d[`HCAD_CUR_W-1:0] = hmon_q[ch];
		`HCAD_OFS_LEAK_MON: rd_d[`HCAD_CUR_W-1:0] = lmon_q[ch];
		`HCAD_OFS_STATUS: begin
			if (!ch) begin
				rd_d[`HCAD_ST_RUN] = run_q;
				if (alm_type_q != `HCAD_TYPE_NONE) begin
					rd_d[`HCAD_ST_HB_LSB+1:`HCAD_ST_HB_LSB] = o_burnout_alarm;
					rd_d[`HCAD_ST_HS_LSB+1:`HCAD_ST_HS_LSB] = o_short_circuit_alarm;
				end
			end
		end
		default: rd_d = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Heating output is registered unchanged, one cycle late; alarms never touch it
	always @(posedge i_core_clk) begin
		if (!i_rst_n)
			o_heat_ctrl <= 1'b0;
		else
			o_heat_ctrl <= i_heat_ctrl;
	end

	// Interval qualification shared by both sensor inputs
	hcad_ivl_timer u_ivl (
		.i_core_clk (i_core_clk),
		.i_rst_n    (core_rst_n),
		.i_level    (i_heat_ctrl),                  // Heating only
		.i_min_cyc  (P_MIN_IVL_CYC),
		.o_on_ok    (on_ok),
		.o_off_ok   (off_ok)
	);

	// One alarm evaluator per sensor input
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_chan
			hcad_alarm_chan u_chan (
				.i_core_clk            (i_core_clk),
				.i_rst_n               (core_rst_n),
				.i_clr                 (errrst_q),
				.i_on_ok               (on_ok),
				.i_off_ok              (off_ok),
				.i_cur                 (cur[g]),
				.i_hb_thr              (hb_thr_q[g]),
				.i_hb_hys              (hb_hys_q[g]),
				.i_hs_thr              (hs_thr_q[g]),
				.i_hs_hys              (hs_act_q[g]),
				.i_hb_latch            (hb_latch_q),
				.i_hs_latch            (hs_latch_q),
				.o_burnout_alarm       (o_burnout_alarm[g]),
				.o_short_circuit_alarm (o_short_circuit_alarm[g])
			);
		end
	endgenerate

endmodule

/* bench/hcad_sense_model.sv */
// Sensor path model: heater load current while heating, leakage when off.
// Assumes the bench sets load, leakage and fault flags just after an edge.
`timescale 1ns/1ps

module hcad_sense_model (
	input  wire        i_core_clk,
	input  wire        i_heat,
	input  wire [10:0] i_load,
	input  wire [10:0] i_leak,
	input  wire [1:0]  i_burnt,
	input  wire [1:0]  i_leaky,
	output reg  [10:0] o_cur_0 = 11'h000,
	output reg  [10:0] o_cur_1 = 11'h000
);
	// One sample a clock; a burnt heater reads zero, an unpowered one zero unless leaky
	always @(posedge i_core_clk) begin
		o_cur_0 <= i_heat ? (i_burnt[0] ? 11'h000 : i_load) : (i_leaky[0] ? i_leak : 11'h000);
		o_cur_1 <= i_heat ? (i_burnt[1] ? 11'h000 : i_load) : (i_leaky[1] ? i_leak : 11'h000);
	end
endmodule

/* bench/hcad_top_props.sv */
// Checker for the heater current alarm detector, channel 0 alarms.
// Assumes only top ports; threshold copies follow completed bus writes.
`timescale 1ns/1ps
`include "hcad_defs.vh"

module hcad_top_props #(
	parameter [`HCAD_CNT_W-1:0] P_MIN_IVL_CYC = `HCAD_MIN_IVL_CYC
) (
	input wire                   i_core_clk,
	input wire                   i_rst_n,
	input wire [`HCAD_AW-1:0]    i_avs_address,
	input wire                   i_avs_read,
	input wire                   i_avs_write,
	input wire [31:0]            i_avs_writedata,
	input wire [31:0]            o_avs_readdata,
	input wire                   o_avs_waitrequest,
	input wire                   i_heat_ctrl,
	input wire [`HCAD_CUR_W-1:0] i_current_sensor_input_0,
	input wire [`HCAD_CUR_W-1:0] i_current_sensor_input_1,
	input wire                   o_heat_ctrl,
	input wire [1:0]             o_burnout_alarm,
	input wire [1:0]             o_short_circuit_alarm
);
	reg  [10:0] burn_q;
	reg  [10:0] sc_q;
	reg  [3:0]  sr_q;
	reg  [23:0] cnt_q;
	reg         lvl_q;
	wire        done = i_avs_write && !o_avs_waitrequest;
	wire        on_ok = i_heat_ctrl && cnt_q >= P_MIN_IVL_CYC;
	wire        off_ok = !i_heat_ctrl && cnt_q >= P_MIN_IVL_CYC;

	// Threshold copies, soft reset history, length of present interval
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			burn_q <= `HCAD_CUR_ZERO;
			sc_q <= `HCAD_CUR_FULL;
			sr_q <= 4'h0;
			cnt_q <= 24'h00_0000;
			lvl_q <= 1'b0;
		end else begin
			if (done && i_avs_address == `HCAD_OFS_HB_THR)
				burn_q <= i_avs_writedata[10:0];
			if (done && i_avs_address == `HCAD_OFS_HS_THR)
				sc_q <= i_avs_writedata[10:0];
			sr_q <= {sr_q[2:0], done && i_avs_address == `HCAD_OFS_CTRL && i_avs_writedata[1]};
			lvl_q <= i_heat_ctrl;
			cnt_q <= (i_heat_ctrl != lvl_q) ? 24'h00_0000 : cnt_q + 24'h00_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	chk_heat_pass: assert property (
		$past(i_rst_n) |-> o_heat_ctrl == $past(i_heat_ctrl))
		else $error("heating output not a plain copy");
	chk_burn_force_on: assert property (
		(burn_q == `HCAD_CUR_FULL && sr_q == 4'h0)[*3] |-> o_burnout_alarm[0])
		else $error("burnout not forced on");
	chk_burn_force_off: assert property (
		(burn_q == `HCAD_CUR_ZERO)[*3] |-> !o_burnout_alarm[0])
		else $error("burnout not forced off");
	chk_short_force_on: assert property (
		(sc_q == `HCAD_CUR_ZERO && sr_q == 4'h0)[*3] |-> o_short_circuit_alarm[0])
		else $error("short not forced on");
	chk_short_force_off: assert property (
		(sc_q == `HCAD_CUR_FULL)[*3] |-> !o_short_circuit_alarm[0])
		else $error("short not forced off");
	chk_burn_long_on: assert property (
		$rose(o_burnout_alarm[0]) && burn_q != `HCAD_CUR_FULL
		|-> on_ok || $past(on_ok) || $past(on_ok, 2) || $past(on_ok, 3))
		else $error("burnout rose outside a long heating interval");
	chk_short_long_off: assert property (
		$rose(o_short_circuit_alarm[0]) && sc_q != `HCAD_CUR_ZERO
		|-> off_ok || $past(off_ok) || $past(off_ok, 2) || $past(off_ok, 3))
		else $error("short rose outside a long off interval");
	chk_wait_one: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus answer not after one wait state");
	chk_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	cov_burn_rise: cover property ($rose(o_burnout_alarm[0]) && burn_q != `HCAD_CUR_FULL);
	cov_short_rise: cover property ($rose(o_short_circuit_alarm[0]) && sc_q != `HCAD_CUR_ZERO);
	cov_read_done: cover property (i_avs_read && !o_avs_waitrequest);
endmodule

bind hcad_top hcad_top_props #(.P_MIN_IVL_CYC(P_MIN_IVL_CYC)) chk_u (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_heat_ctrl(i_heat_ctrl), .i_current_sensor_input_0(i_current_sensor_input_0),
	.i_current_sensor_input_1(i_current_sensor_input_1), .o_heat_ctrl(o_heat_ctrl),
	.o_burnout_alarm(o_burnout_alarm), .o_short_circuit_alarm(o_short_circuit_alarm)
);

/* bench/hcad_top_test.sv */
// Bench for the heater current alarm detector: bus tasks and scenarios.
// Assumes the design, sensor model and checker are compiled before it.
`timescale 1ns/1ps
`include "hcad_defs.vh"

module hcad_top_test;
	localparam P = 20;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         rd = 1'b0;
	reg         wr = 1'b0;
	reg         heat = 1'b0;
	reg  [7:0]  adr = 8'h00;
	reg  [31:0] wdat = 32'h0000_0000;
	reg  [31:0] rv;
	reg  [10:0] load = 11'h000;
	reg  [10:0] leak = 11'h000;
	reg  [1:0]  burnt = 2'b00;
	reg  [1:0]  leaky = 2'b00;
	wire [31:0] rdat;
	wire        wreq;
	wire        heat_o;
	wire [10:0] cur0;
	wire [10:0] cur1;
	wire [1:0]  burn;
	wire [1:0]  sc;
	integer     bad_count;
	integer     num_checks;

	// Design, sensor path, clock
	hcad_top #(.P_MIN_IVL_CYC(P)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_heat_ctrl(heat),
		.i_current_sensor_input_0(cur0), .i_current_sensor_input_1(cur1),
		.o_heat_ctrl(heat_o), .o_burnout_alarm(burn), .o_short_circuit_alarm(sc));
	hcad_sense_model sense_u (.i_core_clk(clk), .i_heat(heat_o), .i_load(load),
		.i_leak(leak), .i_burnt(burnt), .i_leaky(leaky), .o_cur_0(cur0), .o_cur_1(cur1));
	initial forever #4 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	task summarize;
		begin
			$display("checks %0d mismatches %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("BAD %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task chkp(input [8*8:1] nm, input [1:0] e, input [1:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("BAD %0s exp %b got %b", nm, e, g);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// One transfer, held until waitrequest is sampled low
	task bus(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			rd <= !w;
			wr <= w;
			adr <= a;
			wdat <= d;
			n = 0;
			@(posedge clk);
			while (wreq !== 1'b0 && n < 50) begin
				n = n + 1;
				@(posedge clk);
			end
			if (wreq !== 1'b0) begin
				bad_count = bad_count + 1;
				summarize;
			end
			rv = rdat;
			rd <= 1'b0;
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rdc(input [8*8:1] nm, input [7:0] a, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0000_0000);
			chk(nm, e, rv);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	task t_reset;
		begin
			rdc("burnthr", `HCAD_OFS_HB_THR, 32'h0000_0000);
			rdc("burnhys", `HCAD_OFS_HB_HYS, 32'h0000_0001);
			rdc("shortthr", `HCAD_OFS_HS_THR, 32'h0000_03E8);
			rdc("shorthys", `HCAD_OFS_HS_HYS, 32'h0000_0001);
			rdc("cfg", `HCAD_OFS_CFG, 32'h0000_0000);
			bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
			rdc("unmapped", 8'hFC, 32'h0000_0000);
			chkp("burn", 2'b00, burn);
			chkp("short", 2'b00, sc);
		end
	endtask
	// Burnout during heating, hold when off or short, hysteresis band
	task t_burn;
		begin
			bus(1'b1, `HCAD_OFS_HB_THR, 32'h0000_0019);
			bus(1'b1, `HCAD_OFS_HB_HYS, 32'h0000_000A);
			load <= 11'h032;
			heat <= 1'b1;
			cyc(P + 6);
			chkp("burn", 2'b00, burn);
			rdc("curmon", `HCAD_OFS_HCUR_MON, 32'h0000_0032);
			burnt <= 2'b01;
			cyc(6);
			chkp("burn", 2'b01, burn);
			chkp("heat", 2'b01, {1'b0, heat_o});
			heat <= 1'b0;
			burnt <= 2'b00;
			cyc(P + 6);
			chkp("burn", 2'b01, burn);
			heat <= 1'b1;
			cyc(P / 2);
			heat <= 1'b0;
			cyc(4);
			chkp("burn", 2'b01, burn);
			load <= 11'h01E;
			heat <= 1'b1;
			cyc(P + 6);
			chkp("burn", 2'b01, burn);
			load <= 11'h023;
			cyc(4);
			chkp("burn", 2'b00, burn);
		end
	endtask
	task t_force;
		begin
			bus(1'b1, `HCAD_OFS_HB_THR, 32'h0000_03E8);
			cyc(3);
			chkp("burn", 2'b01, burn);
			bus(1'b1, `HCAD_OFS_HB_THR, 32'h0000_0000);
			cyc(3);
			chkp("burn", 2'b00, burn);
			bus(1'b1, `HCAD_OFS_HS_THR, 32'h0000_0000);
			cyc(3);
			chkp("short", 2'b01, sc);
			bus(1'b1, `HCAD_OFS_HS_THR, 32'h0000_03E8);
			cyc(3);
			chkp("short", 2'b00, sc);
		end
	endtask
	// Burnout latch, status gating by alarm type, latch releases
	task t_latch;
		begin
			bus(1'b1, `HCAD_OFS_HB_THR, 32'h0000_0019);
			bus(1'b1, `HCAD_OFS_CFG, 32'h0000_0013);
			burnt <= 2'b01;
			cyc(4);
			burnt <= 2'b00;
			cyc(4);
			chkp("burn", 2'b01, burn);
			rdc("status", `HCAD_OFS_STATUS, 32'h0000_0001);
			bus(1'b1, `HCAD_OFS_CFG, 32'h0000_0001);
			rdc("status", `HCAD_OFS_STATUS, 32'h0000_0000);
			bus(1'b1, `HCAD_OFS_CTRL, 32'h0000_0004);
			cyc(3);
			chkp("burn", 2'b00, burn);
			burnt <= 2'b01;
			cyc(4);
			burnt <= 2'b00;
			bus(1'b1, `HCAD_OFS_HB_THR, 32'h0000_0000);
			cyc(3);
			chkp("burn", 2'b00, burn);
		end
	endtask
	// Short during off time, hold on heating or short off, latch
	task t_short;
		begin
			bus(1'b1, `HCAD_OFS_HS_THR, 32'h0000_000A);
			leak <= 11'h014;
			leaky <= 2'b01;
			heat <= 1'b0;
			cyc(P + 6);
			chkp("short", 2'b01, sc);
			rdc("leakmon", `HCAD_OFS_LEAK_MON, 32'h0000_0014);
			chkp("heat", 2'b00, {1'b0, heat_o});
			leaky <= 2'b00;
			heat <= 1'b1;
			cyc(P + 6);
			chkp("short", 2'b01, sc);
			heat <= 1'b0;
			cyc(P / 2);
			heat <= 1'b1;
			cyc(4);
			chkp("short", 2'b01, sc);
			heat <= 1'b0;
			cyc(P + 6);
			chkp("short", 2'b00, sc);
			bus(1'b1, `HCAD_OFS_CFG, 32'h0000_0002);
			leaky <= 2'b01;
			cyc(4);
			leaky <= 2'b00;
			cyc(4);
			chkp("short", 2'b01, sc);
			bus(1'b1, `HCAD_OFS_CTRL, 32'h0000_0002);
			cyc(3);
			chkp("short", 2'b00, sc);
		end
	endtask
	task t_hys;
		begin
			bus(1'b1, `HCAD_OFS_CTRL, 32'h0000_0001);
			bus(1'b1, `HCAD_OFS_HS_HYS, 32'h0000_0005);
			rdc("shorthys", `HCAD_OFS_HS_HYS, 32'h0000_0001);
			bus(1'b1, `HCAD_OFS_CTRL, 32'h0000_0000);
			bus(1'b1, `HCAD_OFS_HS_HYS, 32'h0000_0005);
			rdc("shorthys", `HCAD_OFS_HS_HYS, 32'h0000_0005);
			// Pending hysteresis idle until soft reset, then widens band
			bus(1'b1, `HCAD_OFS_CFG, 32'h0000_0000);
			leak <= 11'h014;
			leaky <= 2'b01;
			cyc(P + 6);
			chkp("short", 2'b01, sc);
			leak <= 11'h008;
			cyc(4);
			chkp("short", 2'b00, sc);
			bus(1'b1, `HCAD_OFS_CTRL, 32'h0000_0002);
			leak <= 11'h014;
			cyc(P + 6);
			leak <= 11'h008;
			cyc(4);
			chkp("short", 2'b01, sc);
		end
	endtask

	// Reset for twelve cycles, then every scenario in turn
	initial begin
		bad_count = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset;
		t_burn;
		t_force;
		t_latch;
		t_short;
		t_hys;
		summarize;
	end
endmodule
